// ### ifcap_monitor.sv
// Checker for the capture bank ports.
// Assumes binding onto ifcap_regs; one clock domain.
`timescale 1ns/1ps
module ifcap_monitor
	import ifcap_pkg::*;
(
	input wire logic                     clk,
	input wire logic                     arst_n,
	input wire logic                     video_strobe,
	input wire ifcap_pkg::ifcap_video_s  video_in,
	input wire logic                     sound_strobe,
	input wire ifcap_pkg::ifcap_sound_s  sound_in,
	input wire ifcap_pkg::ifcap_decode_s decode
);
	// --------------------------------------------------------
	// Decoded view follows the strobe by two edges
	// --------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	hold_decode_a: assert property ((!video_strobe && !sound_strobe)[*3] |=> $stable(decode))
		else $error("decode moved with no packet");
	bar_field_a: assert property (video_strobe |-> ##2 decode.bar_info == $past(video_in.byte1[3:2], 2))
		else $error("bar field wrong");
	scale_field_a: assert property (video_strobe |-> ##2 decode.scaling_field == $past(video_in.scaling[1:0], 2))
		else $error("scaling field wrong");
	afd_flag_a: assert property (video_strobe |-> ##2 decode.afd_present == $past(video_in.byte1[4], 2))
		else $error("format presence wrong");
	video_code_a: assert property (video_strobe |-> ##2 decode.video_code == $past(video_in.fmt_code[6:0], 2))
		else $error("video code wrong");
	pixel_sends_a: assert property (video_strobe |-> ##2
		decode.pixel_sends == {1'h0, $past(video_in.repeat_cnt[3:0], 2)} + 5'h01)
		else $error("pixel sends wrong");
	coding_type_a: assert property (sound_strobe |-> ##2 decode.coding_type_field == $past(sound_in.coding_count[7:4], 2))
		else $error("coding type wrong");
	chan_count_a: assert property (sound_strobe |-> ##2 decode.channels ==
		($past(sound_in.coding_count[2:0], 2) == 3'h0 ? 4'h0 : {1'h0, $past(sound_in.coding_count[2:0], 2)} + 4'h1))
		else $error("channel count wrong");
endmodule
bind ifcap_regs ifcap_monitor ifcap_monitor_inst (
	.clk(clk), .arst_n(arst_n), .video_strobe(video_strobe), .video_in(video_in),
	.sound_strobe(sound_strobe), .sound_in(sound_in), .decode(decode)
);

// ### ifcap_pkg.sv
// Package for the infoframe capture register bank: offsets, field layout, link capture structs.
// Assumes an APB slave with 32-bit data; each register takes one aligned word (byte addr = 4 * index).
package ifcap_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times these)
	// ----------------------------------------------------------------
	localparam logic [7:0] IFCAP_IDX_BASE       = 8'h80;
	localparam logic [7:0] IFCAP_IDX_VID_VER    = 8'h80;
	localparam logic [7:0] IFCAP_IDX_VID_BYTE1  = 8'h81;
	localparam logic [7:0] IFCAP_IDX_VID_BYTE2  = 8'h82;
	localparam logic [7:0] IFCAP_IDX_SCALING    = 8'h83;
	localparam logic [7:0] IFCAP_IDX_FMT_CODE   = 8'h84;
	localparam logic [7:0] IFCAP_IDX_REPEAT     = 8'h85;
	localparam logic [7:0] IFCAP_IDX_TOP_LO     = 8'h86;
	localparam logic [7:0] IFCAP_IDX_TOP_HI     = 8'h88;
	localparam logic [7:0] IFCAP_IDX_BOT_LO     = 8'h89;
	localparam logic [7:0] IFCAP_IDX_BOT_HI     = 8'h8A;
	localparam logic [7:0] IFCAP_IDX_LEFT_LO    = 8'h8B;
	localparam logic [7:0] IFCAP_IDX_LEFT_HI    = 8'h8C;
	localparam logic [7:0] IFCAP_IDX_RIGHT_LO   = 8'h8D;
	localparam logic [7:0] IFCAP_IDX_RIGHT_HI   = 8'h8E;
	localparam logic [7:0] IFCAP_IDX_SND_VER    = 8'h90;
	localparam logic [7:0] IFCAP_IDX_SND_CODING = 8'h91;
	localparam logic [7:0] IFCAP_IDX_SND_RATE   = 8'h92;
	localparam logic [7:0] IFCAP_IDX_PEAK_RATE  = 8'h93;
	localparam logic [7:0] IFCAP_IDX_SPEAKER    = 8'h94;
	localparam logic [7:0] IFCAP_IDX_IRQ_MASK   = 8'h7E;
	localparam logic [7:0] IFCAP_IDX_IRQ_STATUS = 8'h7F;
	localparam logic [2:0] IFCAP_FLAG_LOW_BITS  = 3'h7;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          IFCAP_NUM_FLAGS  = 7;
	localparam int          IFCAP_FLAG_VIDEO = 0;
	localparam int          IFCAP_FLAG_SOUND = 1;
	localparam logic [7:0]  IFCAP_BYTE_RESET = 8'h00;
	localparam logic [15:0] IFCAP_HALF_RESET = 16'h0000;
	localparam logic [31:0] IFCAP_WORD_ZERO  = 32'h0000_0000;
	localparam logic [1:0]  IFCAP_ADDR_LOW   = 2'h0;
	localparam logic [6:0]  IFCAP_FLAGS_NONE = 7'h00;

	// Bar info encodings
	localparam logic [1:0] IFCAP_BAR_NONE  = 2'h0;
	localparam logic [1:0] IFCAP_BAR_HORIZ = 2'h1;
	localparam logic [1:0] IFCAP_BAR_VERT  = 2'h2;
	localparam logic [1:0] IFCAP_BAR_BOTH  = 2'h3;
	// Active format aspect codes and picture aspect codes
	localparam logic [3:0] IFCAP_AFD_SAME  = 4'h8;
	localparam logic [3:0] IFCAP_AFD_4_3   = 4'h9;
	localparam logic [3:0] IFCAP_AFD_16_9  = 4'hA;
	localparam logic [3:0] IFCAP_AFD_14_9  = 4'hB;
	localparam logic [1:0] IFCAP_PAR_4_3   = 2'h1;
	localparam logic [1:0] IFCAP_PAR_16_9  = 2'h2;

	// Decoded aspect of the active area
	typedef enum logic [2:0] {
		IFCAP_ASPECT_NONE = 3'b000,
		IFCAP_ASPECT_4_3  = 3'b001,
		IFCAP_ASPECT_16_9 = 3'b010,
		IFCAP_ASPECT_14_9 = 3'b011
	} ifcap_aspect_e;

	// Video infoframe fields as delivered by the packet parser
	typedef struct packed {
		logic [7:0]  version;
		logic [7:0]  byte1;
		logic [7:0]  byte2;
		logic [7:0]  scaling;
		logic [7:0]  fmt_code;
		logic [7:0]  repeat_cnt;
		logic [15:0] top_bar_end;
		logic [15:0] bottom_bar_start;
		logic [15:0] left_bar_end;
		logic [15:0] right_bar_start;
	} ifcap_video_s;

	// Audio infoframe fields as delivered by the packet parser
	typedef struct packed {
		logic [7:0] version;
		logic [7:0] coding_count;
		logic [7:0] rate_size;
		logic [7:0] peak_rate;
		logic [7:0] speaker_allocation_code;
	} ifcap_sound_s;

	// Decoded view of the stored fields
	typedef struct packed {
		logic [1:0]    bar_info;
		logic [1:0]    scaling_field;
		logic          afd_present;
		ifcap_aspect_e active_aspect;
		logic [6:0]    video_code;
		logic [4:0]    pixel_sends;
		logic [3:0]    coding_type_field;
		logic [3:0]    channels;
	} ifcap_decode_s;

endpackage

// ### ifcap_regs.sv
// Infoframe capture register bank with APB slave, change flags and interrupt.
// Assumes the packet parser runs on clk and pulses a strobe with complete field data.
`timescale 1ns/1ps
module ifcap_regs
	import ifcap_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Packet parser side
	input  wire logic                    video_strobe,
	input  wire ifcap_pkg::ifcap_video_s video_in,
	input  wire logic                    sound_strobe,
	input  wire ifcap_pkg::ifcap_sound_s sound_in,
	input  wire logic [6:0]              other_changed,
	// Decoded view and interrupt
	output ifcap_pkg::ifcap_decode_s     decode,
	output logic                         irq
);
	import ifcap_pkg::*;

	// ------------------------------------------------------------
	// Stored infoframe contents
	// ------------------------------------------------------------
	ifcap_video_s  video;
	ifcap_sound_s  sound;
	logic [6:0]    change_flags;
	logic [6:0]    irq_status;
	logic [6:0]    irq_mask;
	logic [6:0]    events;
	logic [7:0]    index;
	logic          access;
	logic          rd_access;
	logic          wr_access;
	logic          flag_addr;
	logic          flag_read;
	logic          status_read;
	logic          mapped;
	logic [7:0]    rd_byte;
	logic [31:0]   next_prdata;
	ifcap_decode_s next_decode;

	// Single-cycle access phase; no wait states needed
	assign access    = psel && penable;
	assign rd_access = access && !pwrite;
	assign wr_access = access && pwrite;
	assign index     = paddr[9:2];
	assign pready    = 1'b1;

	// Flag mirrors live at every index ending in 111 in the upper half
	// Address decode alone, so the setup-cycle read capture sees the mirror too
	assign flag_addr   = index[7] && (index[2:0] == IFCAP_FLAG_LOW_BITS);
	assign flag_read   = rd_access && flag_addr;
	assign status_read = rd_access && (index == IFCAP_IDX_IRQ_STATUS);

	// Capture video fields only on a new video packet
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			video <= '0;
		end else if (video_strobe) begin
			video <= video_in;
		end
	end

	// Capture audio fields only on a new audio packet
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sound <= '0;
		end else if (sound_strobe) begin
			sound <= sound_in;
		end
	end

	// Events from both own captures and other packet kinds
	always_comb begin
		events                   = other_changed;
		events[IFCAP_FLAG_VIDEO] = video_strobe || other_changed[IFCAP_FLAG_VIDEO];
		events[IFCAP_FLAG_SOUND] = sound_strobe || other_changed[IFCAP_FLAG_SOUND];
	end

	// Change flags: a new event in the reading cycle survives the clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			change_flags <= IFCAP_FLAGS_NONE;
		end else if (flag_read) begin
			change_flags <= events;
		end else begin
			change_flags <= change_flags | events;
		end
	end

	// Interrupt status: sticky, cleared by reading it, set wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= IFCAP_FLAGS_NONE;
		end else if (status_read) begin
			irq_status <= events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// Interrupt mask, software written
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask <= IFCAP_FLAGS_NONE;
		end else if (wr_access && (index == IFCAP_IDX_IRQ_MASK)) begin
			irq_mask <= pwdata[6:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	always_comb begin
		rd_byte = IFCAP_BYTE_RESET;
		mapped  = 1'b1;
		if (flag_addr) begin
			rd_byte = {1'b0, change_flags};
		end else begin
			unique case (index)
				IFCAP_IDX_VID_VER:    rd_byte = video.version;
				IFCAP_IDX_VID_BYTE1:  rd_byte = video.byte1;
				IFCAP_IDX_VID_BYTE2:  rd_byte = video.byte2;
				IFCAP_IDX_SCALING:    rd_byte = video.scaling;
				IFCAP_IDX_FMT_CODE:   rd_byte = {1'b0, video.fmt_code[6:0]};
				IFCAP_IDX_REPEAT:     rd_byte = {4'h0, video.repeat_cnt[3:0]};
				IFCAP_IDX_TOP_LO:     rd_byte = video.top_bar_end[7:0];
				IFCAP_IDX_TOP_HI:     rd_byte = video.top_bar_end[15:8];
				IFCAP_IDX_BOT_LO:     rd_byte = video.bottom_bar_start[7:0];
				IFCAP_IDX_BOT_HI:     rd_byte = video.bottom_bar_start[15:8];
				IFCAP_IDX_LEFT_LO:    rd_byte = video.left_bar_end[7:0];
				IFCAP_IDX_LEFT_HI:    rd_byte = video.left_bar_end[15:8];
				IFCAP_IDX_RIGHT_LO:   rd_byte = video.right_bar_start[7:0];
				IFCAP_IDX_RIGHT_HI:   rd_byte = video.right_bar_start[15:8];
				IFCAP_IDX_SND_VER:    rd_byte = sound.version;
				IFCAP_IDX_SND_CODING: rd_byte = sound.coding_count;
				IFCAP_IDX_SND_RATE:   rd_byte = sound.rate_size;
				IFCAP_IDX_PEAK_RATE:  rd_byte = sound.peak_rate;
				IFCAP_IDX_SPEAKER:    rd_byte = sound.speaker_allocation_code;
				IFCAP_IDX_IRQ_MASK:   rd_byte = {1'b0, irq_mask};
				IFCAP_IDX_IRQ_STATUS: rd_byte = {1'b0, irq_status};
				default:              mapped  = 1'b0;
			endcase
		end
	end

	// Any access to an unmapped word, a write to a read-only one, bad alignment or paddr[11:10] set is an error
	assign pslverr = access && (!mapped || (paddr[1:0] != IFCAP_ADDR_LOW) || paddr[11:10] != 2'h0
		|| (pwrite && (index != IFCAP_IDX_IRQ_MASK)));

	// Unmapped words already give a zero byte from the multiplexer
	assign next_prdata = {24'h000000, rd_byte};

	// Read data is registered at the setup phase so it is stable in access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= IFCAP_WORD_ZERO;
		end else begin
			prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
		end
	end

	// ------------------------------------------------------------
	// Decoded fields for the downstream video and audio paths
	// ------------------------------------------------------------
	always_comb begin
		next_decode                   = '0;
		next_decode.bar_info          = video.byte1[3:2];
		next_decode.scaling_field     = video.scaling[1:0];
		next_decode.afd_present       = video.byte1[4];
		next_decode.video_code        = video.fmt_code[6:0];
		next_decode.pixel_sends       = {1'b0, video.repeat_cnt[3:0]} + 5'h01;
		next_decode.coding_type_field = sound.coding_count[7:4];
		// Code 0 defers to the stream header, others mean n+1 channels
		next_decode.channels = (sound.coding_count[2:0] == 3'h0) ? 4'h0
			: {1'b0, sound.coding_count[2:0]} + 4'h1;
		next_decode.active_aspect = IFCAP_ASPECT_NONE;
		if (video.byte1[4]) begin
			unique case (video.byte2[3:0])
				IFCAP_AFD_SAME: begin
					if (video.byte2[5:4] == IFCAP_PAR_4_3) begin
						next_decode.active_aspect = IFCAP_ASPECT_4_3;
					end else if (video.byte2[5:4] == IFCAP_PAR_16_9) begin
						next_decode.active_aspect = IFCAP_ASPECT_16_9;
					end
				end
				IFCAP_AFD_4_3:  next_decode.active_aspect = IFCAP_ASPECT_4_3;
				IFCAP_AFD_16_9: next_decode.active_aspect = IFCAP_ASPECT_16_9;
				IFCAP_AFD_14_9: next_decode.active_aspect = IFCAP_ASPECT_14_9;
				default:        next_decode.active_aspect = IFCAP_ASPECT_NONE;
			endcase
		end
	end

	// Registered so the decoded outputs come from flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			decode <= '0;
		end else begin
			decode <= next_decode;
		end
	end

endmodule

// ### ifcap_source.sv
// Link source model: delivers parsed infoframes.
// Assumes the bank samples strobes on rising clk.
`timescale 1ns/1ps
module ifcap_source
	import ifcap_pkg::*;
(
	input wire logic                clk,
	output logic                    video_strobe,
	output ifcap_pkg::ifcap_video_s video_in,
	output logic                    sound_strobe,
	output ifcap_pkg::ifcap_sound_s sound_in,
	output logic [6:0]              other_changed
);
	initial begin
		video_strobe = 1'h0;
		sound_strobe = 1'h0;
		video_in = '1;
		sound_in = '1;
		other_changed = 7'h00;
	end
	// Data inverted after the pulse so stale lines never match
	task automatic send_video(input ifcap_video_s v);
		@(posedge clk);
		video_strobe <= 1'h1;
		video_in <= v;
		@(posedge clk);
		video_strobe <= 1'h0;
		video_in <= ~v;
	endtask
	task automatic send_sound(input ifcap_sound_s s);
		@(posedge clk);
		sound_strobe <= 1'h1;
		sound_in <= s;
		@(posedge clk);
		sound_strobe <= 1'h0;
		sound_in <= ~s;
	endtask
	task automatic send_other(input logic [6:0] f);
		@(posedge clk);
		other_changed <= f;
		@(posedge clk);
		other_changed <= 7'h00;
	endtask
endmodule

// ### tb.sv
// Self-checking bench for the capture bank over APB.
// Assumes ifcap_regs, ifcap_source and the checker.
`timescale 1ns/1ps
module tb;
	import ifcap_pkg::*;
	logic         clk = 1'h0;
	logic         arst_n = 1'h0;
	logic         psel = 1'h0;
	logic         penable = 1'h0;
	logic         pwrite = 1'h0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready, pslverr, irq, vs, ss;
	logic [6:0]   oc;
	ifcap_video_s vin, v;
	ifcap_sound_s sin, s;
	ifcap_decode_s dec;
	int fail_count = 0;
	int num_checks = 0;
	logic [7:0] vi [14] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E};
	logic [7:0] vb [14] = '{8'h02, 8'h1D, 8'h2A, 8'h03, 8'h10, 8'h08, 8'h23, 8'h01, 8'h56, 8'h04, 8'h00, 8'h00, 8'h89, 8'h07};
	logic [7:0] sb [5] = '{8'h01, 8'h27, 8'h0D, 8'h08, 8'h1F};
	ifcap_regs ifcap_regs_inst (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .video_strobe(vs),
		.video_in(vin), .sound_strobe(ss), .sound_in(sin), .other_changed(oc), .decode(dec), .irq(irq));
	ifcap_source ifcap_source_inst (.clk(clk), .video_strobe(vs), .video_in(vin), .sound_strobe(ss),
		.sound_in(sin), .other_changed(oc));
	always #25 clk = ~clk;
	// --------------------------------------------------------
	// Compare, transfer and closing tasks
	// --------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Polls pready, so no latency is assumed
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] exp, input logic err);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, exp};
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		if (!w) chk(prdata, {24'h0, exp});
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Interrupt level is looked at mid-cycle, after the clearing edge has settled
	task automatic chk_irq(input logic exp);
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		xfer(1'h0, 8'h70, 8'h00, 1'h1);
		xfer(1'h1, 8'h81, 8'hFF, 1'h1);
		xfer(1'h0, 8'h81, 8'h00, 1'h0);
		xfer(1'h1, IFCAP_IDX_IRQ_MASK, 8'h01, 1'h0);
		xfer(1'h0, IFCAP_IDX_IRQ_MASK, 8'h01, 1'h0);
		chk_irq(1'h0);
		$display("test refusals done");
		v = {vb[0], vb[1], vb[2], vb[3], vb[4], vb[5], vb[7], vb[6], vb[9], vb[8], vb[11], vb[10], vb[13], vb[12]};
		ifcap_source_inst.send_video(v);
		for (int i = 0; i < 14; i++) xfer(1'h0, vi[i], vb[i], 1'h0);
		chk_irq(1'h1);
		xfer(1'h0, 8'h8F, 8'h01, 1'h0);
		xfer(1'h0, 8'hFF, 8'h00, 1'h0);
		xfer(1'h0, IFCAP_IDX_IRQ_STATUS, 8'h01, 1'h0);
		chk_irq(1'h0);
		$display("test video done");
		s = {sb[0], sb[1], sb[2], sb[3], sb[4]};
		ifcap_source_inst.send_sound(s);
		ifcap_source_inst.send_other(7'h7C);
		for (int i = 0; i < 5; i++) xfer(1'h0, IFCAP_IDX_SND_VER + 8'(i), sb[i], 1'h0);
		chk_irq(1'h0);
		xfer(1'h0, 8'h87, 8'h7E, 1'h0);
		xfer(1'h0, 8'h97, 8'h00, 1'h0);
		chk(32'(dec), 32'(ifcap_decode_s'{2'h3, 2'h3, 1'h1, IFCAP_ASPECT_16_9, 7'h10, 5'h09, 4'h2, 4'h8}));
		$display("test sound done");
		close_out();
	end
endmodule
